// >>> design/srf_top.sv
`timescale 1ns/1ps
// Functional notes
// (R1) long supply dip resets outputs and registers
// (R2) low threshold supply dip resets immediately
// (R3) short supply dip is ignored
// (R4) outputs enabled only after supply valid
// (R5) reset pin acts like supply reset
// (R6) reset pin ignored during deployment
// (R7) supply reset aborts deployment at once
// (R8) reset pin acts after deployment completes
// (R9) reset pin is deglitched
// (R10) notice polarity and mode configurable
// (R11) polling: notice while any fifo holds data
// (R12) interrupt: clear notice at transfer start
// (R13) interrupt: re-arm notice at transfer end
// (R14) bias resistor out of range resets
// (R15) logic ground loss resets
// (R16) power ground loss blocks its channel only
// (R17) hard faults reset and abort deployment
// (R18) soft reset ignored during deployment
// (R19) master keeps serial clock low when idle; no serial clock is modelled here
// (R20) deployment runs to completion unless hard reset
// (R21) filter and deglitch are cycle counters
module srf_top
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // supply monitor comparators, high while below threshold
   input wire logic vdd_below_rst_i,
   input wire logic vdd_below_rst_low_i,
   // external reset pin, active low
   input wire logic ext_reset_n_pin_i,
   // bias resistor monitor and ground monitors
   input wire logic bias_res_upper_limit_i,
   input wire logic bias_res_lower_limit_i,
   input wire logic logic_gnd_lost_i,
   input wire logic [3:0] channel_power_grounds_lost_i,
   // soft reset request and deployment request per channel
   input wire logic soft_reset_i,
   input wire logic [3:0] deploy_req_i,
   // notice configuration
   input wire logic notice_pol_i,
   input wire logic notice_mode_i,
   // fifo occupancy and satellite chip select (high = asserted)
   input wire logic [3:0] fifo_not_empty_i,
   input wire logic sat_cs_i,
   // outputs
   output logic outputs_en_o,
   output logic regs_reset_o,
   output logic [3:0] deploy_drive_o,
   output logic deploy_busy_o,
   output logic fifo_notice_pin_o
);
   // ----------------------------------------------------------------
   // reset sources
   // ----------------------------------------------------------------
   logic vdd_long;
   logic pin_low;
   logic pin_hit;
   logic hard_rst;
   logic pin_rst;
   logic soft_rst;
   logic any_rst;
   logic deploying;
   logic bias_bad;
   // run state is declared here because the reset gating reads it
   srf_pkg::srf_state_e state_r;
   srf_pkg::srf_state_e state_nxt;

   // supply filter: short dips never reach hit  (R21)
   srf_filter #(.LEN(srf_pkg::FILTER_CYC)) u_vdd_filt
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .lvl_i(vdd_below_rst_i),
      .hit_o(vdd_long)
   ); // R1 R3

   // pin deglitch  (R21)
   assign pin_low = ~ext_reset_n_pin_i;
   srf_filter #(.LEN(srf_pkg::GLITCH_CYC)) u_pin_filt
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .lvl_i(pin_low),
      .hit_o(pin_hit)
   ); // R9

   assign bias_bad = bias_res_upper_limit_i | bias_res_lower_limit_i; // R14
   // hard sources act regardless of deployment
   assign hard_rst = vdd_long | vdd_below_rst_low_i | bias_bad
                   | logic_gnd_lost_i; // R2 R15 R17 R7
   // pin and soft reset blocked while deploying
   assign deploying = (state_r == srf_pkg::SRF_DEPLOY);
   assign pin_rst = pin_hit & ~deploying; // R5 R6 R8
   assign soft_rst = soft_reset_i & ~deploying; // R18
   assign any_rst = hard_rst | pin_rst | soft_rst;

   // ----------------------------------------------------------------
   // run state and deployment timer
   // ----------------------------------------------------------------
   logic [15:0] dep_cnt_r;
   logic [15:0] dep_cnt_nxt;
   logic [3:0] dep_ch_r;
   logic [3:0] dep_ch_nxt;
   logic [3:0] dep_ok;
   logic dep_last;
   logic supply_ok;

   localparam logic [15:0] DEP_LAST = 16'(srf_pkg::DEPLOY_CYC - 1);
   // outputs cannot turn on while either supply comparator reads high  (R4)
   assign supply_ok = ~vdd_below_rst_i & ~vdd_below_rst_low_i;
   // a channel without its power ground cannot deploy  (R16)
   assign dep_ok = deploy_req_i & ~channel_power_grounds_lost_i;
   assign dep_last = (dep_cnt_r == DEP_LAST);

   // next state: hard reset always wins, deployment ends only by timer or hard reset
   always_comb
   begin
      state_nxt = state_r;
      dep_cnt_nxt = dep_cnt_r;
      dep_ch_nxt = dep_ch_r;
      case (state_r)
         srf_pkg::SRF_OFF:
         begin
            if (!any_rst && supply_ok)
               state_nxt = srf_pkg::SRF_RUN; // R4
         end
         srf_pkg::SRF_RUN:
         begin
            if (any_rst)
               state_nxt = srf_pkg::SRF_OFF;
            else if (dep_ok != 4'h0)
            begin
               state_nxt = srf_pkg::SRF_DEPLOY;
               dep_cnt_nxt = 16'h0000;
               dep_ch_nxt = dep_ok;
            end
         end
         srf_pkg::SRF_DEPLOY:
         begin
            dep_cnt_nxt = dep_cnt_r + 16'h0001;
            if (hard_rst)
            begin
               state_nxt = srf_pkg::SRF_OFF; // R7 R17
               dep_ch_nxt = 4'h0;
            end
            else if (dep_last)
            begin
               state_nxt = srf_pkg::SRF_RUN; // R20
               dep_ch_nxt = 4'h0;
            end
         end
         default:
         begin
            state_nxt = srf_pkg::SRF_OFF;
            dep_ch_nxt = 4'h0;
         end
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         state_r <= srf_pkg::SRF_OFF;
         dep_cnt_r <= 16'h0000;
         dep_ch_r <= 4'h0;
      end
      else
      begin
         state_r <= state_nxt;
         dep_cnt_r <= dep_cnt_nxt;
         dep_ch_r <= dep_ch_nxt;
      end
   end

   // ----------------------------------------------------------------
   // fifo notice pin
   // ----------------------------------------------------------------
   logic pol_r;
   logic mode_r;
   logic cs_d_r;
   logic cs_rise;
   logic cs_fall;
   logic any_data;
   logic irq_r;
   logic irq_nxt;
   logic notice_act;
   logic cfg_load;

   assign any_data = |fifo_not_empty_i;
   assign cs_rise = sat_cs_i & ~cs_d_r;
   assign cs_fall = ~sat_cs_i & cs_d_r;
   // configuration is latched from the pins while in reset, so a change applies from the next run
   assign cfg_load = (state_r == srf_pkg::SRF_OFF);
   // interrupt latch: set on new data when idle, cleared at cs start
   assign irq_nxt = cs_rise ? 1'b0 :
                    cs_fall ? any_data :
                    (sat_cs_i ? 1'b0 : (irq_r | any_data)); // R12 R13
   // polling follows fifo level directly
   assign notice_act = (mode_r == srf_pkg::MODE_IRQ) ? irq_nxt
                                                     : any_data; // R11

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         pol_r <= srf_pkg::NOTICE_POL_RST;
         mode_r <= srf_pkg::NOTICE_MODE_RST;
         cs_d_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         if (cfg_load)
         begin
            pol_r <= notice_pol_i; // R10
            mode_r <= notice_mode_i; // R10
         end
         cs_d_r <= sat_cs_i;
         irq_r <= irq_nxt & ~cfg_load;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // pin idles at the inactive level, i.e. the inverse of polarity
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         outputs_en_o <= 1'b0;
         regs_reset_o <= 1'b1;
         deploy_drive_o <= 4'h0;
         deploy_busy_o <= 1'b0;
         fifo_notice_pin_o <= ~srf_pkg::NOTICE_POL_RST;
      end
      else
      begin
         outputs_en_o <= (state_nxt != srf_pkg::SRF_OFF); // R4
         regs_reset_o <= (state_nxt == srf_pkg::SRF_OFF); // R1 R2 R14
         deploy_drive_o <= (state_nxt == srf_pkg::SRF_DEPLOY)
                         ? dep_ch_nxt : 4'h0; // R16
         deploy_busy_o <= (state_nxt == srf_pkg::SRF_DEPLOY);
         fifo_notice_pin_o <= (notice_act & ~cfg_load) ? pol_r : ~pol_r;
      end
   end
endmodule

// >>> inc/srf_pkg.sv
package srf_pkg;
   // supply filter time before a slow dip counts as a reset (cycles)
   localparam int unsigned FILTER_CYC = 16;
   // reset pin deglitch time (cycles)
   localparam int unsigned GLITCH_CYC = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned NUM_FIFO = 4;
   localparam int unsigned NUM_CH = 4;
   // deployment length in cycles
   localparam int unsigned DEPLOY_CYC = 64;
   localparam logic [1:0] STRETCH_W = 2'h0;
   // notice pin modes
   localparam logic MODE_POLL = 1'b0;
   localparam logic MODE_IRQ = 1'b1;
   localparam logic NOTICE_POL_RST = 1'b1;
   localparam logic NOTICE_MODE_RST = 1'b0;
   typedef enum logic [1:0] {SRF_OFF, SRF_RUN, SRF_DEPLOY} srf_state_e;
endpackage

// >>> design/srf_filter.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// persistence filter: flags a level held for LEN cycles
// ----------------------------------------------------------------
module srf_filter #(
   parameter int unsigned LEN = 8
)
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // level in, filtered level out
   input wire logic lvl_i,
   output logic hit_o
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic done;
   localparam logic [15:0] LEN_M1 = 16'(LEN - 1);

   // counter saturates at the limit so a long level stays flagged
   assign done = (cnt_r >= LEN_M1);
   assign cnt_nxt = !lvl_i ? 16'h0000 : (done ? cnt_r : cnt_r + 16'h0001);

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         cnt_r <= 16'h0000;
         hit_o <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         hit_o <= lvl_i & done;
      end
   end
endmodule

// >>> dv/srf_top_sva.sv
`timescale 1ns/1ps
// ----------
// port checker
// ----------
module srf_top_chk
(
   input wire logic mclk_i, rst_i, vdd_below_rst_i, vdd_below_rst_low_i,
   input wire logic ext_reset_n_pin_i, bias_res_upper_limit_i,
   input wire logic bias_res_lower_limit_i, logic_gnd_lost_i, soft_reset_i,
   input wire logic [3:0] channel_power_grounds_lost_i, deploy_req_i,
   input wire logic notice_pol_i, notice_mode_i, sat_cs_i,
   input wire logic [3:0] fifo_not_empty_i, deploy_drive_o,
   input wire logic outputs_en_o, regs_reset_o, deploy_busy_o,
   input wire logic fifo_notice_pin_o
);
   logic hard, pol_r, irq_r;
   logic [7:0] dip_r, busy_r;
   assign hard = vdd_below_rst_low_i | bias_res_upper_limit_i |
      bias_res_lower_limit_i | logic_gnd_lost_i;
   // run lengths; config copied only while off, as the block does
   always_ff @(posedge mclk_i)
   begin
      dip_r <= vdd_below_rst_i ? dip_r + 8'h1 : 8'h0;
      busy_r <= deploy_busy_o ? busy_r + 8'h1 : 8'h0;
      if (!outputs_en_o)
      begin
         pol_r <= notice_pol_i;
         irq_r <= notice_mode_i;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   chk_low_thresh:
   assert property (vdd_below_rst_low_i |=> !outputs_en_o && regs_reset_o)
      else $error("low threshold kept outputs");
   chk_bias_range:
   assert property (bias_res_upper_limit_i || bias_res_lower_limit_i |=>
      !outputs_en_o && !deploy_busy_o) else $error("bias fault ignored");
   chk_gnd_loss:
   assert property (logic_gnd_lost_i |=> !outputs_en_o &&
      deploy_drive_o == 4'h0) else $error("ground loss ignored");
   chk_long_dip:
   assert property (dip_r > 8'h12 |-> !outputs_en_o)
      else $error("long dip kept outputs");
   chk_off_stays:
   assert property (!outputs_en_o && vdd_below_rst_i |=> !outputs_en_o)
      else $error("outputs on below threshold");
   chk_deploy_hold:
   assert property (deploy_busy_o && !hard && dip_r == 8'h0 &&
      $past(dip_r) == 8'h0 && busy_r < 8'h3c |=> outputs_en_o)
      else $error("deployment cut short");
   chk_deploy_len:
   assert property ($fell(deploy_busy_o) && outputs_en_o |->
      busy_r == 8'(srf_pkg::DEPLOY_CYC)) else $error("bad deploy length");
   chk_drive_mask:
   assert property ($rose(deploy_busy_o) |-> deploy_drive_o ==
      ($past(deploy_req_i) & ~$past(channel_power_grounds_lost_i)))
      else $error("wrong channels driven");
   chk_poll_level:
   assert property (outputs_en_o && !irq_r |=> !outputs_en_o ||
      fifo_notice_pin_o == (pol_r ^ ~|$past(fifo_not_empty_i)))
      else $error("poll notice wrong");
   chk_irq_clear:
   assert property (outputs_en_o && irq_r && $rose(sat_cs_i) |=>
      !outputs_en_o || fifo_notice_pin_o == ~pol_r)
      else $error("notice not cleared");
   chk_irq_rearm:
   assert property (outputs_en_o && irq_r && $fell(sat_cs_i) &&
      |fifo_not_empty_i |=> !outputs_en_o || fifo_notice_pin_o == pol_r)
      else $error("notice not rearmed");
   cover property ($fell(deploy_busy_o) && outputs_en_o);
   cover property (irq_r && $rose(sat_cs_i));
   cover property ($fell(outputs_en_o) && !hard);
endmodule
bind srf_top srf_top_chk chk_u (.mclk_i, .rst_i, .vdd_below_rst_i,
   .vdd_below_rst_low_i, .ext_reset_n_pin_i, .bias_res_upper_limit_i,
   .bias_res_lower_limit_i, .logic_gnd_lost_i, .soft_reset_i,
   .channel_power_grounds_lost_i, .deploy_req_i, .notice_pol_i,
   .notice_mode_i, .sat_cs_i, .fifo_not_empty_i, .deploy_drive_o,
   .outputs_en_o, .regs_reset_o, .deploy_busy_o, .fifo_notice_pin_o);

// >>> dv/srf_mcu_model.sv
`timescale 1ns/1ps
// ----------
// mcu side: satellite data reads
// ----------
module srf_mcu_model
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [3:0] hold_i,
   output logic sat_cs_o
);
   logic [3:0] left_r;
   // frame length per call, so a slow reader can be modelled
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         left_r <= 4'h0;
      else if (start_i && !sat_cs_o)
         left_r <= hold_i;
      else if (left_r != 4'h0)
         left_r <= left_r - 4'h1;
   end
   // cs idles low; serial clock is not modelled and stays low
   assign sat_cs_o = left_r != 4'h0;
endmodule

// >>> dv/srf_top_test.sv
`timescale 1ns/1ps
module srf_top_test;
   logic mclk_i, rst_i, vb, vl, pn, bh, bl, gl, sr, pol, md, go, cs;
   logic en, rr, busy, ntc;
   logic [3:0] pg, rq, ff, drv, st;
   logic [31:0] rng;
   int errors, tests_run, cyc;
   assign st = {1'b0, busy, rr, en};
   srf_top dut_u (.mclk_i, .rst_i, .vdd_below_rst_i(vb),
      .vdd_below_rst_low_i(vl), .ext_reset_n_pin_i(pn),
      .bias_res_upper_limit_i(bh), .bias_res_lower_limit_i(bl),
      .logic_gnd_lost_i(gl), .channel_power_grounds_lost_i(pg),
      .soft_reset_i(sr), .deploy_req_i(rq), .notice_pol_i(pol),
      .notice_mode_i(md), .fifo_not_empty_i(ff), .sat_cs_i(cs),
      .outputs_en_o(en), .regs_reset_o(rr), .deploy_drive_o(drv),
      .deploy_busy_o(busy), .fifo_notice_pin_o(ntc));
   srf_mcu_model mcu_u (.mclk_i, .rst_i, .start_i(go), .hold_i(4'h4),
      .sat_cs_o(cs));
   // clock and hang guard
   initial
   begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errors++;
         finish_test();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bounded wait for the return to run
   task automatic settle();
      for (int i = 0; i < 40 && en !== 1'b1; i++)
         tick(1);
   endtask
   task automatic finish_test();
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      {vb, vl, bh, bl, gl, sr, go, md, pol, rst_i} = 10'h1;
      {pn, pg, rq, ff} = 13'h1000;
      rng = 32'he8c9;
      tick(5);
      rst_i = 1'b0;
      settle();
      chk(st, 4'h1);
      // random fifo levels, active-low notice
      repeat (200)
      begin
         rng = xs(rng);
         ff = rng[3:0];
         tick(1);
         chk({3'h0, ntc}, {3'h0, ~|ff});
      end
      vb = 1'b1;
      tick(10);
      vb = 1'b0;
      tick(3);
      chk(st, 4'h1);
      vb = 1'b1;
      tick(20);
      chk(st, 4'h2);
      vb = 1'b0;
      settle();
      chk(st, 4'h1);
      pn = 1'b0;
      tick(5);
      pn = 1'b1;
      tick(3);
      chk(st, 4'h1);
      pn = 1'b0;
      tick(12);
      chk(st, 4'h2);
      pn = 1'b1;
      settle();
      // deploy with one dead ground; pin and soft reset held meanwhile
      {pg, rq} = 8'h4f;
      tick(1);
      rq = 4'h0;
      chk(drv, 4'hb);
      {pn, sr} = 2'h1;
      tick(20);
      chk(st, 4'h5);
      sr = 1'b0;
      tick(60);
      chk(st, 4'h2);
      {pn, pg} = 5'h10;
      settle();
      for (int k = 0; k < 4; k++)
      begin
         rq = 4'h1;
         tick(3);
         {vl, bh, bl, gl} = 4'h8 >> k;
         tick(1);
         chk(st, 4'h2);
         {vl, bh, bl, gl, rq} = 8'h0;
         settle();
      end
      // soft reset outside a deployment does reset the block
      sr = 1'b1;
      tick(2);
      chk(st, 4'h2);
      sr = 1'b0;
      settle();
      {md, pol, rst_i, ff} = 7'h72;
      tick(1);
      rst_i = 1'b0;
      settle();
      tick(1);
      chk({3'h0, ntc}, 4'h1);
      for (int k = 1; k >= 0; k--)
      begin
         go = 1'b1;
         tick(1);
         {go, ff} = {1'b0, k[3:0]};
         tick(2);
         chk({3'h0, ntc}, 4'h0);
         tick(6);
         chk({3'h0, ntc}, k[3:0]);
      end
      finish_test();
   end
endmodule
